// ==== logic/ihp_pkg.sv ====
// Constants shared by the indexed host port and its byte lane mapper.
// Assumes a 5-bit host address (A[4:0]) and 16-bit or 8-bit host data lanes.
package ihp_pkg;

   // Host address map of the port
   localparam logic [4:0] HOST_INDEX0 = 5'h00; // Index register of pair 0
   localparam logic [4:0] HOST_DATA0 = 5'h04; // Data register of pair 0
   localparam logic [4:0] HOST_INDEX1 = 5'h08;
   localparam logic [4:0] HOST_DATA1 = 5'h0c;
   localparam logic [4:0] HOST_INDEX2 = 5'h10;
   localparam logic [4:0] HOST_DATA2 = 5'h14;
   localparam logic [4:0] HOST_FIFO_BYPASS = 5'h18; // 18h-1Bh: TX write / RX read
   localparam logic [4:0] HOST_CONFIG = 5'h1c; // Endianness configuration

   // Counter slot that serves both FIFO access methods
   localparam logic [1:0] SLOT_FIFO = 2'h3;

   // Endianness configuration: one bit per pair, one for FIFO access
   localparam int CFG_FIFO_BIT = 3;
   localparam logic [3:0] CFG_RESET = 4'h0;

   // Internal register indexes with special read behaviour
   localparam logic [15:0] TX_STATUS_INDEX = 16'h0040; // Pops on read
   localparam logic [15:0] TX_STATUS_PEEK_INDEX = 16'h0044; // Never pops
   localparam logic [15:0] RX_STATUS_INDEX = 16'h0048;
   localparam logic [15:0] RX_STATUS_PEEK_INDEX = 16'h004c;
   localparam logic [15:0] POLL_INDEX = 16'h0064; // Readable piecewise at init

   // Host accesses per DWORD, less one
   localparam logic [1:0] LAST_OF_16 = 2'h1;
   localparam logic [1:0] LAST_OF_8 = 2'h3;

   // Kind of register a host address reaches
   typedef enum logic [1:0]
   {
      ACC_INDEX = 2'b00,
      ACC_DATA = 2'b01,
      ACC_FIFO = 2'b10,
      ACC_CONFIG = 2'b11
   } ihp_access_e;

endpackage

// ==== logic/ihp_lane_map.sv ====
// Byte lane mapper between a 32-bit little-endian word and the host lanes.
// Purely combinational; the caller picks the word, lane and endianness.
`timescale 1ns/10ps
`default_nettype none
module ihp_lane_map
   import ihp_pkg::*;
(
   input wire logic [31:0] word,
   input wire logic [15:0] wdata,
   input wire logic [1:0] lane,
   input wire logic bus8,
   input wire logic big,
   output logic [15:0] rd_lane,
   output logic [31:0] merged
);

   // Full byte reversal gives the mirrored big-endian view
   function automatic logic [31:0] swap32(input logic [31:0] w);
      swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   logic [31:0] view; // Word in host byte order
   logic [31:0] upd; // Host-order word with the new lane

   // Read selection and write merge share the same host view
   always_comb
   begin
      view = big ? swap32(word) : word;
      upd = view;
      if (bus8)
      begin
         rd_lane = {8'h00, view[8*lane +: 8]};
         upd[8*lane +: 8] = wdata[7:0];
      end
      else
      begin
         rd_lane = view[16*lane[1] +: 16];
         upd[16*lane[1] +: 16] = wdata;
      end
      merged = big ? swap32(upd) : upd;
   end

endmodule
`default_nettype wire

// ==== logic/ihp_host_port.sv ====
// Indexed host port: index/data pairs, FIFO bypass and direct select, endianness.
// Host pins are taken as synchronous to MCLK; straps are static levels.
`timescale 1ns/10ps
`default_nettype none
module ihp_host_port
   import ihp_pkg::*;
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic HOST_CS,
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic [4:0] HOST_ADDR,
   input wire logic FIFO_DIRECT_SELECT,
   input wire logic [15:0] DATA_IN,
   output logic [15:0] DATA_OUT,
   output logic DATA_OE_LO,
   output logic DATA_OE_HI,
   input wire logic BUS_8BIT_MODE,
   input wire logic STROBE_STYLE_STRAP,
   input wire logic SELECT_POLARITY_STRAP,
   input wire logic READ_LINE_POLARITY_STRAP,
   input wire logic WRITE_LINE_POLARITY_STRAP,
   output logic [3:0] CFG_ENDIAN,
   output logic [15:0] REG_RD_INDEX,
   input wire logic [31:0] REG_RDATA,
   output logic REG_RD,
   output logic [15:0] REG_WR_INDEX,
   output logic [31:0] REG_WDATA,
   output logic REG_WR,
   output logic TX_STATUS_POP,
   output logic RX_STATUS_POP,
   input wire logic [31:0] RX_FIFO_DATA,
   output logic RX_FIFO_POP,
   output logic [31:0] TX_FIFO_DATA,
   output logic TX_FIFO_PUSH
);

   // Kind of register an address reaches; direct select overrides the map
   function automatic ihp_access_e kind_of(input logic [4:0] a, input logic fsel);
      if (fsel)
         kind_of = ACC_FIFO;
      else if (a[4:3] == HOST_FIFO_BYPASS[4:3])
         kind_of = a[2] ? ACC_CONFIG : ACC_FIFO;
      else
         kind_of = a[2] ? ACC_DATA : ACC_INDEX;
   endfunction

   // Counter slot: one per pair, one shared by both FIFO methods
   function automatic logic [1:0] slot_of(input logic [4:0] a, input logic fsel);
      slot_of = fsel ? SLOT_FIFO : a[4:3];
   endfunction

   // Strobe decode under strap control
   logic cs_act; // Chip select at its active level
   logic rd_line; // Read line (or direction line) at its active level
   logic wr_line; // Write line (or enable) at its active level
   logic rd_act; // A read cycle is in progress
   logic wr_act; // A write cycle is in progress
   assign cs_act = (HOST_CS == SELECT_POLARITY_STRAP);
   assign rd_line = (HOST_RD == READ_LINE_POLARITY_STRAP);
   assign wr_line = (HOST_WR == WRITE_LINE_POLARITY_STRAP);
   // Style 1: direction line at active level means read, enable qualifies both
   assign rd_act = cs_act & (STROBE_STYLE_STRAP ? (wr_line & rd_line) : rd_line);
   assign wr_act = cs_act & (STROBE_STYLE_STRAP ? (wr_line & ~rd_line) : wr_line);

   // Held state
   logic rd_prev; // Read activity one clock ago
   logic wr_prev; // Write activity one clock ago
   logic [4:0] cap_addr; // Address caught at the leading edge
   logic cap_fsel; // Direct select caught at the leading edge
   logic [15:0] wr_hold; // Last data seen while the write strobe was active
   logic [15:0] idx [0:2]; // Index registers, lower word only
   logic [3:0] cfg; // Endianness bits: pairs 0..2, then FIFO
   logic [1:0] rd_cnt [0:3]; // Read byte/word counters per slot
   logic [1:0] wr_cnt [0:3]; // Write byte/word counters per slot
   logic [31:0] asm_word [0:3]; // DWORD assembly per slot
   logic [31:0] hold; // Read word held through a multi-part read
   logic [15:0] dout; // Registered read lane
   logic pend; // Refetch of the RX head after a burst pop

   // Edge and burst detection
   logic lead_rd;
   logic trail_rd;
   logic lead_wr;
   logic trail_wr;
   logic burst_step; // Address moved under a held direct-select read
   logic a2_tog;
   assign lead_rd = rd_act & ~rd_prev;
   assign trail_rd = ~rd_act & rd_prev;
   assign lead_wr = wr_act & ~wr_prev;
   assign trail_wr = ~wr_act & wr_prev;
   // Burst is recognised only with direct select, reads only
   assign burst_step = rd_act & rd_prev & cap_fsel & FIFO_DIRECT_SELECT
      & (HOST_ADDR != cap_addr);
   assign a2_tog = HOST_ADDR[2] ^ cap_addr[2];

   // Decode of the live address (leading edge, burst) and the caught one
   ihp_access_e cur_kind;
   ihp_access_e cap_kind;
   logic [1:0] cur_slot;
   logic [1:0] cap_slot;
   logic [15:0] cur_index;
   logic [15:0] cap_index;
   logic [1:0] last_cnt;
   logic cap_poll;
   assign cur_kind = kind_of(HOST_ADDR, FIFO_DIRECT_SELECT);
   assign cap_kind = kind_of(cap_addr, cap_fsel);
   assign cur_slot = slot_of(HOST_ADDR, FIFO_DIRECT_SELECT);
   assign cap_slot = slot_of(cap_addr, cap_fsel);
   assign cur_index = (cur_slot == SLOT_FIFO) ? 16'h0000 : idx[cur_slot];
   assign cap_index = (cap_slot == SLOT_FIFO) ? 16'h0000 : idx[cap_slot];
   assign last_cnt = BUS_8BIT_MODE ? LAST_OF_8 : LAST_OF_16;
   assign cap_poll = (cap_kind == ACC_DATA) & (cap_index == POLL_INDEX);

   // Internal read address follows the live address at the leading edge
   assign REG_RD_INDEX = lead_rd ? cur_index : cap_index;

   // Source word for a read; index upper word reads as zero
   logic [31:0] src_word;
   logic cur_poll;
   logic fresh; // First part of a DWORD or a single-part register
   logic [31:0] sel_word;
   logic rd_big;
   assign cur_poll = (cur_kind == ACC_DATA) & (cur_index == POLL_INDEX);
   assign src_word = (cur_kind == ACC_FIFO) ? RX_FIFO_DATA
      : (cur_kind == ACC_DATA) ? REG_RDATA
      : (cur_kind == ACC_INDEX) ? {16'h0000, cur_index}
      : {28'h0000000, cfg};
   // Pollable registers refetch on every read, so repeats stay current
   assign fresh = pend | cur_poll | (rd_cnt[cur_slot] == 2'h0) | (cur_kind == ACC_INDEX)
      | (cur_kind == ACC_CONFIG);
   assign sel_word = (fresh & ~burst_step) | pend ? src_word : hold;
   // FIFO methods follow the FIFO bit, pairs their own bit
   assign rd_big = (cur_kind == ACC_FIFO) ? cfg[CFG_FIFO_BIT]
      : (cur_kind == ACC_DATA) ? cfg[cur_slot] : 1'b0;

   logic [15:0] rd_lane;
   ihp_lane_map rd_map
   (
      .word(sel_word),
      .wdata(16'h0000),
      .lane(HOST_ADDR[1:0]),
      .bus8(BUS_8BIT_MODE),
      .big(rd_big),
      .rd_lane(rd_lane),
      .merged()
   );

   // Write merge uses the caught address and the last strobed data
   logic [31:0] wr_base;
   logic wr_big;
   logic [31:0] wr_merged;
   assign wr_base = (cap_kind == ACC_INDEX) ? {16'h0000, cap_index}
      : (cap_kind == ACC_CONFIG) ? {28'h0000000, cfg} : asm_word[cap_slot];
   assign wr_big = (cap_kind == ACC_FIFO) ? cfg[CFG_FIFO_BIT]
      : (cap_kind == ACC_DATA) ? cfg[cap_slot] : 1'b0;
   ihp_lane_map wr_map
   (
      .word(wr_base),
      .wdata(wr_hold),
      .lane(cap_addr[1:0]),
      .bus8(BUS_8BIT_MODE),
      .big(wr_big),
      .rd_lane(),
      .merged(wr_merged)
   );

   // Completion of reads and writes
   logic rd_evt; // One partial read has been consumed
   logic rd_counted;
   logic rd_last;
   logic wr_counted;
   logic wr_last;
   assign rd_evt = trail_rd | burst_step;
   assign rd_counted = ((cap_kind == ACC_DATA) & ~cap_poll) | (cap_kind == ACC_FIFO);
   // A DWORD boundary in a burst completes the word however many parts were read
   assign rd_last = (rd_cnt[cap_slot] == last_cnt) | (burst_step & a2_tog);
   assign wr_counted = (cap_kind == ACC_DATA) | (cap_kind == ACC_FIFO);
   assign wr_last = wr_counted & (wr_cnt[cap_slot] == last_cnt);

   // Next values of the one-cycle internal strobes
   logic next_reg_rd;
   logic next_rx_pop;
   logic next_tx_sts_pop;
   logic next_rx_sts_pop;
   logic next_reg_wr;
   logic next_tx_push;
   assign next_reg_rd = rd_evt & rd_counted & rd_last & (cap_kind == ACC_DATA);
   assign next_rx_pop = rd_evt & rd_last & (cap_kind == ACC_FIFO);
   // Peek indexes never match, so the status FIFO stays put
   assign next_tx_sts_pop = next_reg_rd & (cap_index == TX_STATUS_INDEX);
   assign next_rx_sts_pop = next_reg_rd & (cap_index == RX_STATUS_INDEX);
   assign next_reg_wr = trail_wr & wr_last & (cap_kind == ACC_DATA);
   assign next_tx_push = trail_wr & wr_last & (cap_kind == ACC_FIFO);

   // Strobe history and the address caught at each leading edge
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rd_prev <= 1'b0;
         wr_prev <= 1'b0;
         cap_addr <= 5'h00;
         cap_fsel <= 1'b0;
      end
      else
      begin
         rd_prev <= rd_act;
         wr_prev <= wr_act;
         // Burst steps move the caught address along with the host
         if (lead_rd | lead_wr | burst_step)
         begin
            cap_addr <= HOST_ADDR;
            cap_fsel <= FIFO_DIRECT_SELECT;
         end
      end
   end

   // Data is sampled every active cycle so the trailing edge needs no hold time
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         wr_hold <= 16'h0000;
      else if (wr_act)
         wr_hold <= BUS_8BIT_MODE ? {8'h00, DATA_IN[7:0]} : DATA_IN;
   end

   // Index and configuration registers take the lower lane at the trailing edge
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         idx[0] <= 16'h0000;
         idx[1] <= 16'h0000;
         idx[2] <= 16'h0000;
         cfg <= CFG_RESET;
      end
      else if (trail_wr & ~cap_addr[1])
      begin
         // Upper-word writes fall outside the stored bits and are dropped
         if (cap_kind == ACC_INDEX)
            idx[cap_slot] <= wr_merged[15:0];
         else if (cap_kind == ACC_CONFIG)
            cfg <= wr_merged[3:0];
      end
   end

   // Counters and DWORD assembly per slot
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         for (int s = 0; s < 4; s++)
         begin
            rd_cnt[s] <= 2'h0;
            wr_cnt[s] <= 2'h0;
            asm_word[s] <= 32'h00000000;
         end
      end
      else
      begin
         if (rd_evt & rd_counted)
            rd_cnt[cap_slot] <= rd_last ? 2'h0 : rd_cnt[cap_slot] + 2'h1;
         if (trail_wr & wr_counted)
         begin
            wr_cnt[cap_slot] <= wr_last ? 2'h0 : wr_cnt[cap_slot] + 2'h1;
            asm_word[cap_slot] <= wr_merged;
         end
      end
   end

   // Read lane register: new lane on a leading edge, burst step or refetch
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         hold <= 32'h00000000;
         dout <= 16'h0000;
         pend <= 1'b0;
      end
      else
      begin
         // The head moves on the edge that takes the pop, so refetch after it
         pend <= RX_FIFO_POP & rd_act;
         if (lead_rd | burst_step | pend)
         begin
            hold <= sel_word;
            dout <= rd_lane;
         end
      end
   end

   // Internal one-cycle strobes and write payloads
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         REG_RD <= 1'b0;
         RX_FIFO_POP <= 1'b0;
         TX_STATUS_POP <= 1'b0;
         RX_STATUS_POP <= 1'b0;
         REG_WR <= 1'b0;
         TX_FIFO_PUSH <= 1'b0;
         REG_WR_INDEX <= 16'h0000;
         REG_WDATA <= 32'h00000000;
         TX_FIFO_DATA <= 32'h00000000;
      end
      else
      begin
         REG_RD <= next_reg_rd;
         RX_FIFO_POP <= next_rx_pop;
         TX_STATUS_POP <= next_tx_sts_pop;
         RX_STATUS_POP <= next_rx_sts_pop;
         REG_WR <= next_reg_wr;
         TX_FIFO_PUSH <= next_tx_push;
         if (next_reg_wr)
         begin
            REG_WR_INDEX <= cap_index;
            REG_WDATA <= wr_merged;
         end
         if (next_tx_push)
            TX_FIFO_DATA <= wr_merged;
      end
   end

   // Lanes are driven from the second cycle of a read on; upper lanes never in 8-bit mode
   assign DATA_OUT = BUS_8BIT_MODE ? {8'h00, dout[7:0]} : dout;
   assign DATA_OE_LO = rd_act & rd_prev;
   assign DATA_OE_HI = rd_act & rd_prev & ~BUS_8BIT_MODE;
   assign CFG_ENDIAN = cfg;

endmodule
`default_nettype wire

// ==== tb/ihp_host_port_checker.sv ====
// Concurrent checks of the indexed host port outputs against its host pins.
// Sees only the top module ports; bound to every instance at the foot.
`timescale 1ns/10ps
`default_nettype none
module ihp_host_port_checker
   import ihp_pkg::*;
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic HOST_CS,
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic [4:0] HOST_ADDR,
   input wire logic FIFO_DIRECT_SELECT,
   input wire logic DATA_OE_LO,
   input wire logic DATA_OE_HI,
   input wire logic BUS_8BIT_MODE,
   input wire logic STROBE_STYLE_STRAP,
   input wire logic SELECT_POLARITY_STRAP,
   input wire logic READ_LINE_POLARITY_STRAP,
   input wire logic WRITE_LINE_POLARITY_STRAP,
   input wire logic [3:0] CFG_ENDIAN,
   input wire logic [15:0] REG_RD_INDEX,
   input wire logic REG_RD,
   input wire logic REG_WR,
   input wire logic TX_STATUS_POP,
   input wire logic RX_STATUS_POP,
   input wire logic RX_FIFO_POP,
   input wire logic TX_FIFO_PUSH
);
   // Lines at their strap-chosen active level
   wire logic cs_on = (HOST_CS == SELECT_POLARITY_STRAP);
   wire logic rd_line = (HOST_RD == READ_LINE_POLARITY_STRAP);
   wire logic wr_line = (HOST_WR == WRITE_LINE_POLARITY_STRAP);
   // Style 1 makes the read line a direction and the write line an enable
   wire logic rd_act = cs_on && (STROBE_STYLE_STRAP ? (wr_line && rd_line) : rd_line);
   wire logic wr_act = cs_on && (STROBE_STYLE_STRAP ? (wr_line && !rd_line) : wr_line);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   // Read strobe seen on two edges in a row
   sequence s_rd_held;
      rd_act ##1 rd_act;
   endsequence
   // Address bit 2 flips while a direct-select read is held
   sequence s_a2_flip;
      rd_act && FIFO_DIRECT_SELECT ##1 rd_act && FIFO_DIRECT_SELECT && $changed(HOST_ADDR[2]);
   endsequence
   a_oe_during_read: assert property (s_rd_held |-> DATA_OE_LO)
      else $error("lanes not driven during a held read");
   a_oe_after_read: assert property (!rd_act |-> !DATA_OE_LO && !DATA_OE_HI)
      else $error("lanes driven without a read");
   a_upper_lanes: assert property (DATA_OE_HI |-> DATA_OE_LO && !BUS_8BIT_MODE)
      else $error("upper lanes driven wrongly");
   a_write_at_end: assert property ((REG_WR || TX_FIFO_PUSH) |-> $past(wr_act, 2) && !$past(wr_act))
      else $error("write pulse not one cycle after strobe end");
   a_read_at_end: assert property (REG_RD |-> $past(rd_act, 2) && !$past(rd_act))
      else $error("internal read not one cycle after strobe end");
   a_tx_status_pop: assert property (TX_STATUS_POP |-> REG_RD && REG_RD_INDEX == TX_STATUS_INDEX)
      else $error("transmit status pop without its read");
   a_rx_status_pop: assert property (REG_RD && REG_RD_INDEX == RX_STATUS_INDEX |-> RX_STATUS_POP)
      else $error("receive status read did not pop");
   a_peek_no_pop: assert property (REG_RD && (REG_RD_INDEX == TX_STATUS_PEEK_INDEX ||
      REG_RD_INDEX == RX_STATUS_PEEK_INDEX) |-> !TX_STATUS_POP && !RX_STATUS_POP)
      else $error("peek read advanced a status fifo");
   a_burst_pop: assert property (s_a2_flip |-> ##[1:2] RX_FIFO_POP)
      else $error("no pop after dword boundary in burst");
   a_cfg_by_write: assert property ($changed(CFG_ENDIAN) |-> $past(wr_act, 2) || $past(wr_act, 3))
      else $error("configuration changed without a write");
endmodule
bind ihp_host_port ihp_host_port_checker ihp_host_port_checker_inst
(
   .MCLK(MCLK), .RSTN(RSTN), .HOST_CS(HOST_CS), .HOST_RD(HOST_RD), .HOST_WR(HOST_WR),
   .HOST_ADDR(HOST_ADDR), .FIFO_DIRECT_SELECT(FIFO_DIRECT_SELECT), .DATA_OE_LO(DATA_OE_LO),
   .DATA_OE_HI(DATA_OE_HI), .BUS_8BIT_MODE(BUS_8BIT_MODE), .STROBE_STYLE_STRAP(STROBE_STYLE_STRAP),
   .SELECT_POLARITY_STRAP(SELECT_POLARITY_STRAP), .READ_LINE_POLARITY_STRAP(READ_LINE_POLARITY_STRAP),
   .WRITE_LINE_POLARITY_STRAP(WRITE_LINE_POLARITY_STRAP), .CFG_ENDIAN(CFG_ENDIAN),
   .REG_RD_INDEX(REG_RD_INDEX), .REG_RD(REG_RD), .REG_WR(REG_WR), .TX_STATUS_POP(TX_STATUS_POP),
   .RX_STATUS_POP(RX_STATUS_POP), .RX_FIFO_POP(RX_FIFO_POP), .TX_FIFO_PUSH(TX_FIFO_PUSH)
);
`default_nettype wire

// ==== tb/ihp_host_model.sv ====
// Host controller model: drives the host pins in either strobe style.
// Assumes its tasks are entered just after a rising edge of MCLK.
`timescale 1ns/10ps
`default_nettype none
module ihp_host_model
#(
   parameter logic CS_POL = 1'b0,
   parameter logic RD_POL = 1'b1,
   parameter logic WR_POL = 1'b0
)
(
   input wire logic MCLK,
   input wire logic style,
   output logic HOST_CS,
   output logic HOST_RD,
   output logic HOST_WR,
   output logic [4:0] HOST_ADDR,
   output logic FIFO_DIRECT_SELECT,
   output logic [15:0] DATA_IN,
   output logic look
);
   // Idle bus: all lines at their inactive level
   initial
   begin
      HOST_CS = ~CS_POL;
      HOST_RD = ~RD_POL;
      HOST_WR = ~WR_POL;
      HOST_ADDR = 5'h00;
      FIFO_DIRECT_SELECT = 1'b0;
      DATA_IN = 16'h0000;
      look = 1'b0;
   end
   // Opens an access and marks when read data must be settled
   task automatic start(input logic rd, input logic [4:0] a, input logic ds, input logic [15:0] d);
      HOST_CS <= CS_POL;
      HOST_RD <= rd ? RD_POL : ~RD_POL;
      HOST_WR <= (rd && !style) ? ~WR_POL : WR_POL;
      HOST_ADDR <= a;
      FIFO_DIRECT_SELECT <= ds;
      if (!rd)
         DATA_IN <= d;
      repeat (2) @(posedge MCLK);
      look <= rd;
      @(posedge MCLK);
      look <= 1'b0;
   endtask
   // Burst step: strobe stays on, only the address moves
   task automatic move(input logic [4:0] a);
      HOST_ADDR <= a;
      repeat (4) @(posedge MCLK);
      look <= 1'b1;
      @(posedge MCLK);
      look <= 1'b0;
   endtask
   // Closes the access; released data lines show the inverse, never a stale value
   task automatic stop();
      HOST_CS <= ~CS_POL;
      HOST_RD <= ~RD_POL;
      HOST_WR <= ~WR_POL;
      DATA_IN <= ~DATA_IN;
      repeat (2) @(posedge MCLK);
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_ihp_host_port.sv ====
// Self-checking bench for the indexed host port in 16-bit mode.
// Internal register file and RX data FIFO are modelled here.
`timescale 1ns/10ps
`default_nettype none
module tb_ihp_host_port;
   import ihp_pkg::*;
   localparam logic CS_POL = 1'b0;
   localparam logic RD_POL = 1'b1;
   localparam logic WR_POL = 1'b0;
   logic MCLK, RSTN, HOST_CS, HOST_RD, HOST_WR, FIFO_DIRECT_SELECT, look, style = 1'b0;
   logic DATA_OE_LO, DATA_OE_HI, REG_RD, REG_WR, TX_STATUS_POP, RX_STATUS_POP, RX_FIFO_POP, TX_FIFO_PUSH;
   logic [4:0] HOST_ADDR;
   logic [3:0] CFG_ENDIAN;
   logic [15:0] DATA_IN, DATA_OUT, REG_RD_INDEX, REG_WR_INDEX, rx_n = 16'h0100, seed, w0, w1;
   logic [31:0] REG_RDATA, REG_WDATA, RX_FIFO_DATA, TX_FIFO_DATA;
   logic [15:0] st_idx [4] = '{TX_STATUS_INDEX, TX_STATUS_PEEK_INDEX, RX_STATUS_INDEX, RX_STATUS_PEEK_INDEX};
   logic [47:0] q_wr[$]; // Expected {index, data} of internal writes
   logic [31:0] q_tx[$]; // Expected TX FIFO words
   logic [15:0] q_rd[$]; // Expected host read lanes
   int err_count = 0, n_tests = 0, n_rd = 0, n_txs = 0, n_rxs = 0, n_pop = 0, p;
   function automatic logic [15:0] sw(input logic [15:0] v);
      return {v[7:0], v[15:8]};
   endfunction
   // Register file contents: distinct bytes so any swap shows
   function automatic logic [31:0] rdat(input logic [15:0] i);
      return {i ^ 16'h5a3c, i};
   endfunction
   // Host word w of a little-endian dword, as little or big host sees it
   function automatic logic [15:0] lane(input logic [31:0] v, input logic w, input logic big);
      return big ? sw(w ? v[15:0] : v[31:16]) : (w ? v[31:16] : v[15:0]);
   endfunction
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   assign REG_RDATA = rdat(REG_RD_INDEX);
   assign RX_FIFO_DATA = {rx_n, ~rx_n};
   initial
   begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   ihp_host_model #(.CS_POL(CS_POL), .RD_POL(RD_POL), .WR_POL(WR_POL)) host_inst
   (
      .MCLK(MCLK), .style(style), .HOST_CS(HOST_CS), .HOST_RD(HOST_RD), .HOST_WR(HOST_WR), .HOST_ADDR(HOST_ADDR),
      .FIFO_DIRECT_SELECT(FIFO_DIRECT_SELECT), .DATA_IN(DATA_IN), .look(look)
   );
   ihp_host_port ihp_host_port_inst
   (
      .MCLK(MCLK), .RSTN(RSTN), .HOST_CS(HOST_CS), .HOST_RD(HOST_RD), .HOST_WR(HOST_WR),
      .HOST_ADDR(HOST_ADDR), .FIFO_DIRECT_SELECT(FIFO_DIRECT_SELECT), .DATA_IN(DATA_IN),
      .DATA_OUT(DATA_OUT), .DATA_OE_LO(DATA_OE_LO), .DATA_OE_HI(DATA_OE_HI), .BUS_8BIT_MODE(1'b0),
      .STROBE_STYLE_STRAP(style), .SELECT_POLARITY_STRAP(CS_POL), .READ_LINE_POLARITY_STRAP(RD_POL),
      .WRITE_LINE_POLARITY_STRAP(WR_POL), .CFG_ENDIAN(CFG_ENDIAN), .REG_RD_INDEX(REG_RD_INDEX),
      .REG_RDATA(REG_RDATA), .REG_RD(REG_RD), .REG_WR_INDEX(REG_WR_INDEX), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .TX_STATUS_POP(TX_STATUS_POP), .RX_STATUS_POP(RX_STATUS_POP),
      .RX_FIFO_DATA(RX_FIFO_DATA), .RX_FIFO_POP(RX_FIFO_POP), .TX_FIFO_DATA(TX_FIFO_DATA),
      .TX_FIFO_PUSH(TX_FIFO_PUSH)
   );
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d, comparisons %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One read with its expected lane noted first
   task automatic rd(input logic [4:0] a, input logic ds, input logic [15:0] e);
      q_rd.push_back(e);
      host_inst.start(1'b1, a, ds, 16'h0000);
      host_inst.stop();
   endtask
   task automatic wr(input logic [4:0] a, input logic ds, input logic [15:0] d);
      host_inst.start(1'b0, a, ds, d);
      host_inst.stop();
   endtask
   // Takes the oldest note whenever a result shows; empty queue never matches
   always @(posedge MCLK)
   begin
      if (look === 1'b1)
         chk(48'(DATA_OUT), q_rd.size() ? 48'(q_rd.pop_front()) : '1);
      if (REG_WR === 1'b1)
         chk({REG_WR_INDEX, REG_WDATA}, q_wr.size() ? q_wr.pop_front() : '1);
      if (TX_FIFO_PUSH === 1'b1)
         chk(48'(TX_FIFO_DATA), q_tx.size() ? 48'(q_tx.pop_front()) : '1);
      n_rd += (REG_RD === 1'b1);
      n_txs += (TX_STATUS_POP === 1'b1);
      n_rxs += (RX_STATUS_POP === 1'b1);
      // Popping moves the FIFO head to a fresh value
      if (RX_FIFO_POP === 1'b1)
      begin
         n_pop++;
         rx_n <= rx_n + 16'h0001;
      end
   end
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge MCLK);
      err_count++;
      finish_test();
   end
   initial
   begin
      RSTN = 1'b0;
      seed = 16'h0026;
      repeat (8) @(posedge MCLK);
      RSTN <= 1'b1;
      @(posedge MCLK);
      // Pair 1 and FIFO big endian, pairs 0 and 2 little
      wr(HOST_CONFIG, 1'b0, 16'h000a);
      rd(HOST_CONFIG, 1'b0, 16'h000a);
      chk(48'(CFG_ENDIAN), 48'h00000000000a);
      wr(HOST_INDEX0, 1'b0, 16'h0120);
      wr(HOST_INDEX0 | 5'h02, 1'b0, 16'hffff);
      rd(HOST_INDEX0, 1'b0, 16'h0120);
      rd(HOST_INDEX0 | 5'h02, 1'b0, 16'h0000);
      wr(HOST_INDEX1, 1'b0, 16'h0120);
      // Same register through a little and a big pair, words in either order
      rd(HOST_DATA0 | 5'h02, 1'b0, lane(rdat(16'h0120), 1'b1, 1'b0));
      rd(HOST_DATA0, 1'b0, lane(rdat(16'h0120), 1'b0, 1'b0));
      rd(HOST_DATA1, 1'b0, lane(rdat(16'h0120), 1'b0, 1'b1));
      rd(HOST_DATA1 | 5'h02, 1'b0, lane(rdat(16'h0120), 1'b1, 1'b1));
      seed = lfsr(seed);
      w0 = seed;
      seed = lfsr(seed);
      w1 = seed;
      wr(HOST_INDEX2, 1'b0, 16'h0200);
      q_wr.push_back({16'h0200, w1, w0});
      wr(HOST_DATA2 | 5'h02, 1'b0, w1);
      wr(HOST_DATA2, 1'b0, w0);
      // Half by bypass, half by direct select: one shared big-endian assembly
      q_tx.push_back({sw(w0), sw(w1)});
      wr(HOST_FIFO_BYPASS, 1'b0, w0);
      wr(5'h16, 1'b1, w1);
      wr(HOST_CONFIG, 1'b0, 16'h0000);
      q_tx.push_back({w1, w0});
      wr(5'h0e, 1'b1, w1);
      wr(5'h00, 1'b1, w0);
      p = n_pop;
      rd(HOST_FIFO_BYPASS, 1'b0, lane({rx_n, ~rx_n}, 1'b0, 1'b0));
      rd(HOST_FIFO_BYPASS | 5'h02, 1'b0, lane({rx_n, ~rx_n}, 1'b1, 1'b0));
      repeat (2) @(posedge MCLK);
      chk(48'(n_pop - p), 48'h000000000001);
      // Burst of four dwords with the read strobe held throughout
      p = n_pop;
      w0 = rx_n;
      q_rd.push_back(lane({w0, ~w0}, 1'b0, 1'b0));
      host_inst.start(1'b1, 5'h00, 1'b1, 16'h0000);
      for (int k = 1; k < 8; k++)
      begin
         w1 = w0 + 16'(k / 2);
         q_rd.push_back(lane({w1, ~w1}, k[0], 1'b0));
         host_inst.move({k[3:0], 1'b0});
      end
      host_inst.stop();
      repeat (2) @(posedge MCLK);
      chk(48'(n_pop - p), 48'h000000000004);
      // Status FIFOs in direction plus enable style: normal reads pop, peeks do not
      style <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         wr(HOST_INDEX0, 1'b0, st_idx[i]);
         rd(HOST_DATA0, 1'b0, lane(rdat(st_idx[i]), 1'b0, 1'b0));
         rd(HOST_DATA0 | 5'h02, 1'b0, lane(rdat(st_idx[i]), 1'b1, 1'b0));
      end
      repeat (2) @(posedge MCLK);
      chk(48'(n_txs), 48'h000000000001);
      chk(48'(n_rxs), 48'h000000000001);
      // Pollable register: one word read twice, no internal read
      wr(HOST_INDEX0, 1'b0, POLL_INDEX);
      p = n_rd;
      rd(HOST_DATA0, 1'b0, lane(rdat(POLL_INDEX), 1'b0, 1'b0));
      rd(HOST_DATA0, 1'b0, lane(rdat(POLL_INDEX), 1'b0, 1'b0));
      repeat (2) @(posedge MCLK);
      chk(48'(n_rd - p), 48'h000000000000);
      chk(48'(q_rd.size() + q_wr.size() + q_tx.size()), 48'h000000000000);
      finish_test();
   end
endmodule
`default_nettype wire
